// file: stfd_pkg.sv
// package: constants and types for the sheet tester fault display
package stfd_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SELFTEST_MS     = 10_000;
  localparam int unsigned WARMUP_MS       = 180_000;
  localparam int unsigned FLASH_MS        = 250;
  localparam int unsigned SPIN_MS         = 100;
  localparam int unsigned SELFTEST_CYC    = SELFTEST_MS * (CLK_HZ / 1000);
  // wider than 32 bits: three minutes of cycles would wrap an int
  localparam longint unsigned WARMUP_CYC  = longint'(WARMUP_MS) * longint'(CLK_HZ / 1000);
  localparam int unsigned FLASH_CYC       = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned SPIN_CYC        = SPIN_MS * (CLK_HZ / 1000);
  localparam logic [6:0]  ERR_NONE        = 7'h00;
  localparam logic [6:0]  ERR_PATH_BUSY   = 7'h58; // 88
  localparam logic [6:0]  ERR_PRESEL      = 7'h59; // 89
  localparam logic [6:0]  ERR_US_BUSY     = 7'h5A; // 90
  localparam logic [6:0]  ERR_US_LOW      = 7'h5B; // 91
  localparam logic [6:0]  ERR_CAP_RANGE   = 7'h5C; // 92
  localparam logic [6:0]  ERR_CAP_GAINSW  = 7'h5D; // 93
  localparam logic [6:0]  ERR_CAP_HIGAIN  = 7'h5E; // 94
  localparam logic [6:0]  ERR_CAP_WARM    = 7'h5F; // 95
  localparam logic [6:0]  SEG_ALL         = 7'h7F;
  localparam logic [6:0]  SEG_OFF         = 7'h00;
  typedef enum logic [1:0] {ST_LAMP, ST_WARM, ST_RUN} stfd_state_t;
endpackage : stfd_pkg

// file: stfd_if.sv
// interface: error code carrier between core and digit decoder
interface stfd_if;
  logic [6:0] code;
  logic [6:0] seg_tens;
  logic [6:0] seg_ones;
  modport core (output code, input seg_tens, seg_ones);
  modport dec  (input code, output seg_tens, seg_ones);
endinterface : stfd_if

// file: stfd_digit_dec.sv
// module: two-digit seven-segment decoder with registered outputs
module stfd_digit_dec
  import stfd_pkg::*;
(
  input  wire logic core_clk_in, // clock
  input  wire logic rst_in,      // sync reset
  stfd_if.dec       dig          // code in, segments out
);
  logic [6:0] tens_d, ones_d, tens_q, ones_q;
  logic [3:0] t, o;

  function automatic logic [6:0] seg7(input logic [3:0] v);
    case (v)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction : seg7

  always_comb begin
    t      = 4'(dig.code / 7'd10);
    o      = 4'(dig.code % 7'd10);
    tens_d = seg7(t);
    ones_d = seg7(o);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tens_q <= 7'h00;
      ones_q <= 7'h00;
    end else begin
      tens_q <= tens_d;
      ones_q <= ones_d;
    end
  end

  assign dig.seg_tens = tens_q;
  assign dig.seg_ones = ones_q;
endmodule : stfd_digit_dec

// file: stfd_top.sv
// module: fault and status indication of the sheet tester
module stfd_top
  import stfd_pkg::*;
#(
  parameter int unsigned SELFTEST_CYCLES = SELFTEST_CYC, // self test length
  parameter longint unsigned WARMUP_CYCLES = WARMUP_CYC, // capacitive warm-up
  parameter int unsigned FLASH_CYCLES    = FLASH_CYC,    // flash half period
  parameter int unsigned SPIN_CYCLES     = SPIN_CYC      // bar step period
)(
  input  wire logic       core_clk_in,       // 200 MHz clock
  input  wire logic       rst_in,            // sync reset, active high
  input  wire logic       activation_in,     // activation control input
  input  wire logic       calibration_in,    // calibration control input
  input  wire logic       path_busy_in,      // measurement path occupied
  input  wire logic       presel_mismatch_in, // presets differ from state
  input  wire logic       us_path_busy_in,   // ultrasonic path occupied
  input  wire logic       us_level_low_in,   // ultrasonic level below limit
  input  wire logic       cap_out_window_in, // capacitive signal out of window
  input  wire logic       cap_gainsw_fail_in, // gain switching failed
  input  wire logic       cap_hi_bad_in,     // high-gain signal out of window
  input  wire logic       cap_sensor_sel_in, // capacitive sensor configured
  input  wire logic       cap_high_gain_in,  // high gain stage selected
  input  wire logic       mode23_info_in,    // two-of-three mode status bit
  output logic      [6:0] seg_left_out,      // left digit segments a..g
  output logic      [6:0] seg_right_out,     // right digit segments a..g
  output logic            dp_left_out,       // left decimal point
  output logic            dp_right_out,      // right decimal point
  output logic            led_yellow_out,    // yellow lamp
  output logic            led_green_out,     // green lamp
  output logic            led_red_out,       // red lamp
  output logic            ref_discard_out,   // one-cycle: drop stored reference
  output logic            ready_out          // normal indication active
);
  // ****************************************
  // state and timers
  // ****************************************
  stfd_state_t st_d, st_q;
  logic [35:0] tmr_d, tmr_q;
  logic [6:0]  err_d, err_q;
  logic        act_q, cal_q, act_d, cal_d;
  logic        fl_d, fl_q;
  logic [31:0] flc_d, flc_q;
  logic [2:0]  spin_d, spin_q;
  logic [31:0] spc_d, spc_q;
  logic        disc_d, disc_q;
  logic        act_rise, cal_rise, clr;
  logic [6:0]  new_err;
  stfd_if      dig ();

  stfd_digit_dec u_dec (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .dig         (dig)
  );

  assign act_rise = activation_in & ~act_q;
  assign cal_rise = calibration_in & ~cal_q;
  assign clr      = act_rise | cal_rise;

  // later checks win so the newest detection is shown
  always_comb begin
    new_err = ERR_NONE;
    if (st_q == ST_LAMP && tmr_q == 36'd0 && us_path_busy_in)
      new_err = ERR_US_BUSY;
    if (st_q == ST_LAMP && us_level_low_in && !us_path_busy_in)
      new_err = ERR_US_LOW;
    if (st_q == ST_LAMP && cap_sensor_sel_in && cap_out_window_in)
      new_err = ERR_CAP_RANGE;
    if (st_q == ST_LAMP && cap_sensor_sel_in && cap_gainsw_fail_in)
      new_err = ERR_CAP_GAINSW;
    if (st_q == ST_LAMP && cap_sensor_sel_in && cap_hi_bad_in)
      new_err = ERR_CAP_HIGAIN;
    if (st_q == ST_WARM && st_d == ST_RUN && cap_out_window_in)
      new_err = ERR_CAP_WARM;
    if (st_q == ST_RUN && act_rise && presel_mismatch_in)
      new_err = ERR_PRESEL;
    if (st_q == ST_RUN && act_rise && path_busy_in)
      new_err = ERR_PATH_BUSY;
  end

  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q + 36'd1;
    act_d  = activation_in;
    cal_d  = calibration_in;
    // reference is dropped even when a higher code wins the display
    disc_d = (st_q == ST_LAMP && tmr_q == 36'd0 && us_path_busy_in);
    case (st_q)
      ST_LAMP: if (tmr_q >= 36'(SELFTEST_CYCLES - 1)) begin
        st_d  = cap_sensor_sel_in ? ST_WARM : ST_RUN;
        tmr_d = 36'd0;
      end
      ST_WARM: if (tmr_q >= 36'(WARMUP_CYCLES - 1)) begin
        st_d  = ST_RUN;
        tmr_d = 36'd0;
      end
      ST_RUN:  tmr_d = tmr_q;
      default: st_d = ST_LAMP;
    endcase
    // new error beats a clear in the same cycle
    err_d = err_q;
    if (clr)
      err_d = ERR_NONE;
    if (new_err != ERR_NONE)
      err_d = new_err;
    flc_d = flc_q + 32'd1;
    fl_d  = fl_q;
    if (flc_q >= 32'(FLASH_CYCLES - 1)) begin
      flc_d = 32'd0;
      fl_d  = ~fl_q;
    end
    spc_d  = spc_q + 32'd1;
    spin_d = spin_q;
    if (spc_q >= 32'(SPIN_CYCLES - 1)) begin
      spc_d  = 32'd0;
      spin_d = (spin_q == 3'd5) ? 3'd0 : spin_q + 3'd1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q   <= ST_LAMP;
      tmr_q  <= 36'd0;
      err_q  <= ERR_NONE;
      act_q  <= 1'b0;
      cal_q  <= 1'b0;
      fl_q   <= 1'b0;
      flc_q  <= 32'd0;
      spin_q <= 3'd0;
      spc_q  <= 32'd0;
      disc_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      err_q  <= err_d;
      act_q  <= act_d;
      cal_q  <= cal_d;
      fl_q   <= fl_d;
      flc_q  <= flc_d;
      spin_q <= spin_d;
      spc_q  <= spc_d;
      disc_q <= disc_d;
    end
  end

  assign dig.code = err_q;

  // ****************************************
  // display composition
  // ****************************************
  logic [6:0] sl_d, sr_d, sl_q, sr_q;
  logic       dl_d, dr_d, dl_q, dr_q, ly_d, lg_d, lr_d, ly_q, lg_q, lr_q;

  always_comb begin
    sl_d = SEG_OFF;
    sr_d = SEG_OFF;
    dl_d = mode23_info_in;
    dr_d = cap_high_gain_in;
    ly_d = 1'b0;
    lg_d = 1'b1;
    lr_d = 1'b0;
    if (err_q != ERR_NONE) begin
      sl_d = fl_q ? dig.seg_tens : SEG_OFF;
      sr_d = fl_q ? dig.seg_ones : SEG_OFF;
      lg_d = 1'b0;
      lr_d = 1'b1;
    end else if (st_q == ST_LAMP) begin
      sl_d = SEG_ALL;
      sr_d = SEG_ALL;
      dl_d = 1'b1;
      dr_d = 1'b1;
      ly_d = 1'b1;
      lr_d = 1'b1;
    end else if (st_q == ST_WARM) begin
      sl_d = 7'(7'h01 << spin_q);
      sr_d = 7'(7'h01 << spin_q);
      lg_d = 1'b0;
    end else begin
      sr_d = {5'h00, calibration_in, activation_in};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sl_q <= SEG_ALL;
      sr_q <= SEG_ALL;
      dl_q <= 1'b1;
      dr_q <= 1'b1;
      ly_q <= 1'b1;
      lg_q <= 1'b1;
      lr_q <= 1'b1;
    end else begin
      sl_q <= sl_d;
      sr_q <= sr_d;
      dl_q <= dl_d;
      dr_q <= dr_d;
      ly_q <= ly_d;
      lg_q <= lg_d;
      lr_q <= lr_d;
    end
  end

  assign seg_left_out    = sl_q;
  assign seg_right_out   = sr_q;
  assign dp_left_out     = dl_q;
  assign dp_right_out    = dr_q;
  assign led_yellow_out  = ly_q;
  assign led_green_out   = lg_q;
  assign led_red_out     = lr_q;
  assign ref_discard_out = disc_q;
  assign ready_out       = (st_q == ST_RUN);

  // ****************************************
  // checks
  // ****************************************
  property p_path_busy;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_RUN && act_rise && path_busy_in) |=> (err_q == ERR_PATH_BUSY);
  endproperty
  a_path_busy: assert property (p_path_busy) else $error("error 88 not flagged");

  property p_presel;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_RUN && act_rise && presel_mismatch_in && !path_busy_in) |=> (err_q == ERR_PRESEL);
  endproperty
  a_presel: assert property (p_presel) else $error("error 89 not flagged");

  property p_us_busy;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_LAMP && tmr_q == 36'd0 && us_path_busy_in && !cap_sensor_sel_in)
        |=> (err_q == ERR_US_BUSY && ref_discard_out);
  endproperty
  a_us_busy: assert property (p_us_busy) else $error("error 90 or discard missing");

  property p_clear;
    @(posedge core_clk_in) disable iff (rst_in)
      (clr && new_err == ERR_NONE) |=> (err_q == ERR_NONE) ##1 (!led_red_out || $past(st_q) == ST_LAMP);
  endproperty
  a_clear: assert property (p_clear) else $error("error not cleared by pulse");

  property p_lamp;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_LAMP && err_q == ERR_NONE) |=> (seg_left_out == SEG_ALL && led_yellow_out && dp_left_out);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test incomplete");

  property p_ready_green;
    @(posedge core_clk_in) disable iff (rst_in)
      (ready_out && err_q == ERR_NONE) ##1 (err_q == ERR_NONE) |-> (led_green_out && !led_red_out);
  endproperty
  a_ready_green: assert property (p_ready_green) else $error("green lamp wrong");

  property p_gain_dp;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q != ST_LAMP && st_d != ST_LAMP) |=> (dp_right_out == $past(cap_high_gain_in));
  endproperty
  a_gain_dp: assert property (p_gain_dp) else $error("gain point wrong");

  property p_mode_dp;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q != ST_LAMP && st_d != ST_LAMP) |=> (dp_left_out == $past(mode23_info_in));
  endproperty
  a_mode_dp: assert property (p_mode_dp) else $error("mode point wrong");

  property p_warm;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_q == ST_WARM && err_q == ERR_NONE) |=> ($onehot(seg_left_out) && !led_green_out);
  endproperty
  a_warm: assert property (p_warm) else $error("rotating bar wrong during warm-up");
endmodule : stfd_top

// file: stfd_ctrl_model.sv
// model: machine controller driving the control inputs of the fault display
module stfd_ctrl_model #(
  parameter int unsigned PULSE_CYCLES = 3 // shortened minimum pulse length
)(
  input  wire logic clk_in,          // bench clock
  input  wire logic act_hold_in,     // keep activation switched on
  input  wire logic act_pulse_in,    // strobe: one activation pulse
  input  wire logic cal_pulse_in,    // strobe: one calibration pulse
  output logic      activation_out,  // activation control level
  output logic      calibration_out  // calibration control level
);
  int unsigned act_cnt = 0;
  int unsigned cal_cnt = 0;
  // changes only at the falling edge, so the block never samples a moving level
  always @(negedge clk_in) begin
    act_cnt <= act_pulse_in ? PULSE_CYCLES : (act_cnt != 0 ? act_cnt - 1 : 0);
    cal_cnt <= cal_pulse_in ? PULSE_CYCLES : (cal_cnt != 0 ? cal_cnt - 1 : 0);
  end
  assign activation_out  = act_hold_in | (act_cnt != 0);
  assign calibration_out = (cal_cnt != 0);
endmodule : stfd_ctrl_model

// file: tb_top.sv
// testbench: self-checking bench for the sheet tester fault display
module tb_top import stfd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 20;
  localparam int WU = 50;
  localparam int FL = 4;
  localparam int SP = 2;
  typedef struct packed {
    logic [5:0] flt;
    logic       hold, red, disc;
    logic [6:0] right;
  } stfd_row_t;
  logic       clk = 1'h0, rst = 1'h1, act_hold = 1'h0, act_pulse = 1'h0, cal_pulse = 1'h0;
  logic       path_busy = 1'h0, presel = 1'h0, us_busy = 1'h0, us_low = 1'h0, cap_out = 1'h0;
  logic       gainsw = 1'h0, hibad = 1'h0, cap_sel = 1'h0, hi_gain = 1'h0, m23 = 1'h0, disc_seen = 1'h0;
  logic       act, cal, dp_l, dp_r, led_y, led_g, led_r, disc, rdy;
  logic [6:0] seg_l, seg_r;
  logic [13:0] snap;
  int         failures = 0, total_checks = 0, cycles = 0, n;
  stfd_row_t  rows [8];
  always #2.5 clk = ~clk;
  stfd_top #(.SELFTEST_CYCLES(ST), .WARMUP_CYCLES(WU), .FLASH_CYCLES(FL), .SPIN_CYCLES(SP)) u_stfd_top (
    .core_clk_in(clk), .rst_in(rst), .activation_in(act), .calibration_in(cal), .path_busy_in(path_busy),
    .presel_mismatch_in(presel), .us_path_busy_in(us_busy), .us_level_low_in(us_low), .cap_out_window_in(cap_out),
    .cap_gainsw_fail_in(gainsw), .cap_hi_bad_in(hibad), .cap_sensor_sel_in(cap_sel), .cap_high_gain_in(hi_gain),
    .mode23_info_in(m23), .seg_left_out(seg_l), .seg_right_out(seg_r), .dp_left_out(dp_l), .dp_right_out(dp_r),
    .led_yellow_out(led_y), .led_green_out(led_g), .led_red_out(led_r), .ref_discard_out(disc), .ready_out(rdy));
  stfd_ctrl_model u_stfd_ctrl_model (.clk_in(clk), .act_hold_in(act_hold), .act_pulse_in(act_pulse),
    .cal_pulse_in(cal_pulse), .activation_out(act), .calibration_out(cal));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string name, input logic [6:0] seen, input logic [6:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  task automatic do_reset();
    rst <= 1'h1;
    step(20);
    check("lamp test segs", seg_l & seg_r, SEG_ALL);
    check("lamp test dots", 7'({dp_l, dp_r, led_y, led_g, led_r}), 7'h1F);
    disc_seen <= 1'h0;
    rst <= 1'h0;
  endtask : do_reset
  task automatic wait_ready(output int k);
    k = 0;
    while (rdy !== 1'h1 && k < 300) begin
      step(1);
      k++;
    end
  endtask : wait_ready
  // only the right digit is watched: every one of its glyphs 0..9 lights at least one segment
  task automatic wait_lit();
    for (int i = 0; i < 4 * FL && seg_r === SEG_OFF; i++) step(1);
  endtask : wait_lit
  task automatic pulse(input logic on_cal);
    if (on_cal) cal_pulse <= 1'h1;
    else act_pulse <= 1'h1;
    step(1);
    cal_pulse <= 1'h0;
    act_pulse <= 1'h0;
    step(6);
  endtask : pulse
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    if (disc === 1'h1) disc_seen <= 1'h1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      report_and_stop();
    end
  end
  // ****************************************
  // stimulus
  // ****************************************
  // fault bits: us_busy, us_low, cap_out, gainsw, hibad, cap_sel
  initial begin
    rows[0] = '{6'h00, 1'h0, 1'h0, 1'h0, 7'h00};
    rows[1] = '{6'h20, 1'h0, 1'h1, 1'h1, 7'h3F};
    rows[2] = '{6'h10, 1'h0, 1'h1, 1'h0, 7'h06};
    rows[3] = '{6'h09, 1'h0, 1'h1, 1'h0, 7'h5B};
    rows[4] = '{6'h05, 1'h0, 1'h1, 1'h0, 7'h4F};
    rows[5] = '{6'h03, 1'h0, 1'h1, 1'h0, 7'h66};
    rows[6] = '{6'h09, 1'h1, 1'h1, 1'h0, 7'h6D};
    rows[7] = '{6'h06, 1'h0, 1'h0, 1'h0, 7'h00}; // gain faults without capacitive sensor are ignored
    foreach (rows[i]) begin
      {us_busy, us_low, cap_out, gainsw, hibad, cap_sel} <= rows[i].flt;
      do_reset();
      step(10);
      // an error found at once takes the display over from the lamp test
      if (!rows[i].red) check("self test segs", seg_l & seg_r, SEG_ALL);
      check("self test lamps", 7'({led_y, led_r}), rows[i].red ? 7'h01 : 7'h03);
      check("self test ready", 7'(rdy), 7'h00);
      step(ST);
      check("ready after self test", 7'(rdy), 7'(!rows[i].flt[0]));
      {us_busy, us_low, cap_out, gainsw, hibad} <= {2'h0, rows[i].hold, 2'h0};
      wait_ready(n);
      cap_out <= 1'h0;
      step(3);
      if (rows[i].red) wait_lit();
      check("red lamp", 7'(led_r), 7'(rows[i].red));
      check("green lamp", 7'(led_g), 7'(!rows[i].red));
      check("right digit", seg_r, rows[i].right);
      check("reference drop", 7'(disc_seen), 7'(rows[i].disc));
    end
    cap_sel <= 1'h1;
    do_reset();
    step(ST + 10);
    snap = {seg_l, seg_r};
    step(SP);
    check("bar moves", 7'({seg_l, seg_r} !== snap), 7'h01);
    check("bar not lamp test", 7'({seg_l, seg_r} !== {SEG_ALL, SEG_ALL}), 7'h01);
    check("warm-up ready", 7'(rdy), 7'h00);
    wait_ready(n);
    step(4);
    check("ready after warm-up", 7'({rdy, led_g, led_r}), 7'h06);
    for (int i = 0; i < 2; i++) begin
      hi_gain <= i[0];
      m23 <= ~i[0];
      step(4);
      check("right point", 7'(dp_r), 7'(i[0]));
      check("left point", 7'(dp_l), 7'(!i[0]));
    end
    act_hold <= 1'h1;
    step(4);
    check("activation segment", seg_r, 7'h01);
    act_hold <= 1'h0;
    path_busy <= 1'h1;
    pulse(1'h0);
    wait_lit();
    check("code 88", seg_l & seg_r, 7'h7F);
    check("error lamps", 7'({led_g, led_r}), 7'h01);
    n = 0;
    repeat (3 * FL) begin
      step(1);
      n += (seg_r === SEG_OFF);
    end
    check("flashing", 7'(n > 0 && n < 3 * FL), 7'h01);
    path_busy <= 1'h0;
    presel <= 1'h1;
    pulse(1'h0);
    wait_lit();
    check("newest code", 7'(seg_l === 7'h7F && seg_r !== 7'h7F), 7'h01);
    presel <= 1'h0;
    pulse(1'h1);
    check("calibration clears", 7'({led_g, led_r}), 7'h02);
    path_busy <= 1'h1;
    pulse(1'h0);
    path_busy <= 1'h0;
    pulse(1'h0);
    check("activation clears", 7'({led_g, led_r}), 7'h02);
    do_reset();
    check("ready after reset", 7'(rdy), 7'h00);
    report_and_stop();
  end
endmodule : tb_top
